//--- ors_params.svh
/*
  Register offsets, field positions, reset values and timing figures for the
  dual-role session controller. Assumes a 40 MHz logic clock and byte
  addressing on a 32-bit classic Wishbone bus.
*/
`ifndef ORS_PARAMS_SVH
`define ORS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ORS_ADR_CTRL 8'h00
`define ORS_ADR_STATUS 8'h04
`define ORS_ADR_RAMP 8'h08
`define ORS_ADR_AWAIT 8'h0c
`define ORS_ADR_SUSP 8'h10
`define ORS_ADR_DEB 8'h14
`define ORS_ADR_HOLD 8'h18
`define ORS_ADR_RST 8'h1c
`define ORS_ADR_ACK 8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ORS_C_BUS_USE 0
`define ORS_C_DROP 1
`define ORS_C_ENUM_DONE 2
`define ORS_C_SUPPORTED 3
`define ORS_C_PERMIT_OK 4
`define ORS_C_PERMIT_STALL 5
`define ORS_C_SUSP_NOPERMIT 6
`define ORS_C_CLR_ERR 7
`define ORS_C_SWAP_CAPABLE 8

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ORS_S_STATE_LO 0
`define ORS_S_STATE_HI 2
`define ORS_S_DRIVE 3
`define ORS_S_PULLUP 4
`define ORS_S_LINK_SUSP 5
`define ORS_S_ATTACHED 6
`define ORS_S_UNSUPPORTED 7
`define ORS_S_INCAPABLE 8
`define ORS_S_PERMIT 9
`define ORS_S_ARMED 10
`define ORS_S_RETURN_DUE 11
`define ORS_S_B_START 12

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define ORS_CLK_MHZ 40
`define ORS_T_ACK_PULLUP_US 3000
`define ORS_T_CONN_HOLD_US 3000
`define ORS_T_BUS_RESET_US 10000
`define ORS_T_DEBOUNCE_US 2500
`define ORS_T_RAMP_US 100000
`define ORS_T_AWAIT_US 1000000
`define ORS_T_SUSP_US 200000
`define ORS_TMR_MAX 32'hffffffff

`endif

//--- ors_pkg.sv
/*
  Types shared by the dual-role session controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ors_pkg;

  // ----------------------------------------------------------------
  // Session states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_REST,
    S_RAMP,
    S_AWAIT,
    S_HOSTING,
    S_SUSPENDED,
    S_PERIPHERAL,
    S_POWER_DOWN,
    S_OVERCURRENT
  } ors_state_t;

endpackage

//--- ors_timer.sv
/*
  State timer: counts cycles since the last restart and flags when the
  programmed limit is reached. Assumes restart pulses on each state change.
*/
`timescale 1ns/1ps
`include "ors_params.svh"

module ors_timer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic [31:0] limit,
  output logic [31:0] count,
  output logic expired
);

  logic [31:0] count_r;
  logic [31:0] count_nxt;

  always_comb begin
    if (restart) begin
      count_nxt = 32'h0;
    end else if (count_r == `ORS_TMR_MAX) begin
      count_nxt = count_r;
    end else begin
      count_nxt = count_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= 32'h0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  assign expired = (count_r >= limit);

endmodule

//--- ors_fsm.sv
/*
  Default-host session controller of a dual-role USB device with the role
  swap timing, behind a classic Wishbone register slave.
  Assumes line levels, supply comparators and plug sense are synchronous
  to ref_clk; enumeration and SetFeature traffic run in software.
*/
// Overview of operation
// - Suspend link when done with permit set
// - Pull-up on quickly after peer detach
// - Hold attach at least connect hold time
// - Armed SE0 watcher enables pull-up itself
// - Attach only after peer detach seen
// - Cable removal passes power down, rest
// - Rest to ramp on request, no drop
// - Ramp to await on supply or timeout
// - Await to hosting on peer attach
// - Await to power down on plug/drop/timeout
// - Await to overcurrent on supply loss
// - Drive bus reset entering hosting
// - Enumerate, report, then clear bus request
// - Grant permit; stall marks incapable; suspend
// - Suspend without permit, return later
// - Hosting to await on plug/drop/detach
// - Hosting to overcurrent on supply loss
// - State timer restarts on state change
// - Power down to rest on session end
// - Attach after debounced D+/D- high
`timescale 1ns/1ps
`include "ors_params.svh"

module ors_fsm #(
  parameter int unsigned RAMP_CYC = `ORS_T_RAMP_US * `ORS_CLK_MHZ,
  parameter int unsigned AWAIT_CYC = `ORS_T_AWAIT_US * `ORS_CLK_MHZ,
  parameter int unsigned SUSP_CYC = `ORS_T_SUSP_US * `ORS_CLK_MHZ,
  parameter int unsigned DEB_CYC = `ORS_T_DEBOUNCE_US * `ORS_CLK_MHZ,
  parameter int unsigned HOLD_CYC = `ORS_T_CONN_HOLD_US * `ORS_CLK_MHZ,
  parameter int unsigned RST_CYC = `ORS_T_BUS_RESET_US * `ORS_CLK_MHZ,
  parameter int unsigned ACK_CYC = `ORS_T_ACK_PULLUP_US * `ORS_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic plug_sense,
  input wire logic supply_valid,
  input wire logic supply_session_valid,
  input wire logic session_request_seen,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic local_tx_active,
  output logic drive_supply,
  output logic pullup_en,
  output logic bus_reset_drive,
  output logic sof_enable,
  output logic link_suspend,
  output logic role_b_start
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ors_merge(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic ors_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  ors_pkg::ors_state_t state_r, state_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] ramp_r, ramp_nxt, await_r, await_nxt, susp_r, susp_nxt;
  logic [31:0] deb_r, deb_nxt, hold_r, hold_nxt, rst_r, rst_nxt, ackt_r, ackt_nxt;
  logic unsup_r, unsup_nxt, incap_r, incap_nxt;
  logic [31:0] status;
  logic wr_fire;
  logic [31:0] wr_val;
  logic enum_done, permit_ok, permit_stall, susp_nopermit, clr_err;

  // Writes land at the edge where the master sees ack
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wr_val = ors_merge(32'h0, wb_dat_i, wb_sel_i);
  assign enum_done = wr_fire & ors_hit(wb_adr_i, `ORS_ADR_CTRL) & wr_val[`ORS_C_ENUM_DONE];
  assign permit_ok = wr_fire & ors_hit(wb_adr_i, `ORS_ADR_CTRL) & wr_val[`ORS_C_PERMIT_OK];
  assign permit_stall = wr_fire & ors_hit(wb_adr_i, `ORS_ADR_CTRL) & wr_val[`ORS_C_PERMIT_STALL];
  assign susp_nopermit = wr_fire & ors_hit(wb_adr_i, `ORS_ADR_CTRL) & wr_val[`ORS_C_SUSP_NOPERMIT];
  assign clr_err = wr_fire & ors_hit(wb_adr_i, `ORS_ADR_CTRL) & wr_val[`ORS_C_CLR_ERR];

  logic attached_r, permit_r, armed_r, pullup_r;
  logic [31:0] tmr_count;
  logic tmr_expired;
  logic reset_done;

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    dat_nxt = dat_r;
    if (wb_cyc_i && wb_stb_i && !ack_r) begin
      unique case (wb_adr_i)
        `ORS_ADR_CTRL: dat_nxt = ctrl_r;
        `ORS_ADR_STATUS: dat_nxt = status;
        `ORS_ADR_RAMP: dat_nxt = ramp_r;
        `ORS_ADR_AWAIT: dat_nxt = await_r;
        `ORS_ADR_SUSP: dat_nxt = susp_r;
        `ORS_ADR_DEB: dat_nxt = deb_r;
        `ORS_ADR_HOLD: dat_nxt = hold_r;
        `ORS_ADR_RST: dat_nxt = rst_r;
        `ORS_ADR_ACK: dat_nxt = ackt_r;
        default: dat_nxt = 32'h0;
      endcase
    end
    ctrl_nxt = ctrl_r;
    if (wr_fire && ors_hit(wb_adr_i, `ORS_ADR_CTRL)) begin
      // Action bits are pulses and never stored
      ctrl_nxt = ors_merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000010b;
    end
    if (state_r == ors_pkg::S_HOSTING && enum_done && reset_done) begin
      ctrl_nxt[`ORS_C_BUS_USE] = 1'b0;
    end
    ramp_nxt = ramp_r;
    await_nxt = await_r;
    susp_nxt = susp_r;
    deb_nxt = deb_r;
    hold_nxt = hold_r;
    rst_nxt = rst_r;
    ackt_nxt = ackt_r;
    if (wr_fire) begin
      unique case (wb_adr_i)
        `ORS_ADR_RAMP: ramp_nxt = ors_merge(ramp_r, wb_dat_i, wb_sel_i);
        `ORS_ADR_AWAIT: await_nxt = ors_merge(await_r, wb_dat_i, wb_sel_i);
        `ORS_ADR_SUSP: susp_nxt = ors_merge(susp_r, wb_dat_i, wb_sel_i);
        `ORS_ADR_DEB: deb_nxt = ors_merge(deb_r, wb_dat_i, wb_sel_i);
        `ORS_ADR_HOLD: hold_nxt = ors_merge(hold_r, wb_dat_i, wb_sel_i);
        `ORS_ADR_RST: rst_nxt = ors_merge(rst_r, wb_dat_i, wb_sel_i);
        `ORS_ADR_ACK: ackt_nxt = ors_merge(ackt_r, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    // Sticky flags: a new event beats a same-cycle write-one clear
    unsup_nxt = unsup_r;
    incap_nxt = incap_r;
    if (wr_fire && ors_hit(wb_adr_i, `ORS_ADR_STATUS)) begin
      unsup_nxt = unsup_r & ~wr_val[`ORS_S_UNSUPPORTED];
      incap_nxt = incap_r & ~wr_val[`ORS_S_INCAPABLE];
    end
    if (state_r == ors_pkg::S_HOSTING && enum_done && reset_done && !wr_val[`ORS_C_SUPPORTED]) begin
      unsup_nxt = 1'b1;
    end
    if (state_r == ors_pkg::S_HOSTING && permit_stall) begin
      incap_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      ctrl_r <= 32'h0;
      ramp_r <= RAMP_CYC;
      await_r <= AWAIT_CYC;
      susp_r <= SUSP_CYC;
      deb_r <= DEB_CYC;
      hold_r <= HOLD_CYC;
      rst_r <= RST_CYC;
      ackt_r <= ACK_CYC;
      unsup_r <= 1'b0;
      incap_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      ramp_r <= ramp_nxt;
      await_r <= await_nxt;
      susp_r <= susp_nxt;
      deb_r <= deb_nxt;
      hold_r <= hold_nxt;
      rst_r <= rst_nxt;
      ackt_r <= ackt_nxt;
      unsup_r <= unsup_nxt;
      incap_r <= incap_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------------------------------
  // Line sensing and attach debounce
  // ----------------------------------------------------------------
  logic line_se0, line_k, line_j;
  logic [31:0] att_cnt_r, att_cnt_nxt, idle_cnt_r, idle_cnt_nxt;
  logic attached_nxt, att_keep;

  assign line_se0 = ~line_dp & ~line_dm;
  assign line_k = ~line_dp & line_dm;
  assign line_j = line_dp & ~line_dm;
  assign att_keep = (state_r == ors_pkg::S_AWAIT) | (state_r == ors_pkg::S_HOSTING) |
                    (state_r == ors_pkg::S_SUSPENDED);

  always_comb begin
    attached_nxt = attached_r;
    att_cnt_nxt = 32'h0;
    if (!att_keep) begin
      attached_nxt = 1'b0;
    end else if ((line_dp | line_dm) != attached_r) begin
      // Level must differ for the whole debounce before it counts
      if (att_cnt_r + 32'h1 >= deb_r) begin
        attached_nxt = ~attached_r;
      end else begin
        att_cnt_nxt = att_cnt_r + 32'h1;
      end
    end
    idle_cnt_nxt = 32'h0;
    if (state_r == ors_pkg::S_PERIPHERAL && line_j && idle_cnt_r != `ORS_TMR_MAX) begin
      idle_cnt_nxt = idle_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      attached_r <= 1'b0;
      att_cnt_r <= 32'h0;
      idle_cnt_r <= 32'h0;
    end else begin
      attached_r <= attached_nxt;
      att_cnt_r <= att_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Session state machine
  // ----------------------------------------------------------------
  logic drop, detach_seen, tmr_restart;
  logic [31:0] tmr_limit;
  logic permit_nxt, armed_nxt, pullup_nxt;

  assign drop = ctrl_r[`ORS_C_DROP];
  assign reset_done = tmr_count >= rst_r;
  // Armed watcher catches the peer detach with no software round trip
  assign detach_seen = armed_r & line_se0 & ~local_tx_active;
  assign tmr_restart = state_r != state_nxt;

  always_comb begin
    unique case (state_r)
      ors_pkg::S_RAMP: tmr_limit = ramp_r;
      ors_pkg::S_AWAIT: tmr_limit = await_r;
      ors_pkg::S_SUSPENDED: tmr_limit = susp_r;
      default: tmr_limit = `ORS_TMR_MAX;
    endcase
  end

  ors_timer u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .restart(tmr_restart),
    .limit(tmr_limit),
    .count(tmr_count),
    .expired(tmr_expired)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ors_pkg::S_REST: begin
        if (!plug_sense && !drop && (ctrl_r[`ORS_C_BUS_USE] || session_request_seen)) begin
          state_nxt = ors_pkg::S_RAMP;
        end
      end
      ors_pkg::S_RAMP: begin
        if (plug_sense || drop) begin
          state_nxt = ors_pkg::S_POWER_DOWN;
        end else if (supply_valid || tmr_expired) begin
          state_nxt = ors_pkg::S_AWAIT;
        end
      end
      ors_pkg::S_AWAIT: begin
        if (plug_sense || drop || tmr_expired) begin
          state_nxt = ors_pkg::S_POWER_DOWN;
        end else if (!supply_valid) begin
          state_nxt = ors_pkg::S_OVERCURRENT;
        end else if (attached_r) begin
          state_nxt = ors_pkg::S_HOSTING;
        end
      end
      ors_pkg::S_HOSTING: begin
        if (plug_sense || drop || !attached_r) begin
          state_nxt = ors_pkg::S_AWAIT;
        end else if (!supply_valid) begin
          state_nxt = ors_pkg::S_OVERCURRENT;
        end else if (reset_done && (permit_ok || susp_nopermit)) begin
          state_nxt = ors_pkg::S_SUSPENDED;
        end
      end
      ors_pkg::S_SUSPENDED: begin
        if (plug_sense || drop || tmr_expired) begin
          state_nxt = ors_pkg::S_POWER_DOWN;
        end else if (!supply_valid) begin
          state_nxt = ors_pkg::S_OVERCURRENT;
        end else if (detach_seen) begin
          state_nxt = ors_pkg::S_PERIPHERAL;
        end else if (!attached_r) begin
          state_nxt = ors_pkg::S_AWAIT;
        end else if (line_k || ctrl_r[`ORS_C_BUS_USE]) begin
          state_nxt = ors_pkg::S_HOSTING;
        end
      end
      ors_pkg::S_PERIPHERAL: begin
        if (plug_sense || drop) begin
          state_nxt = ors_pkg::S_POWER_DOWN;
        end else if (!supply_valid) begin
          state_nxt = ors_pkg::S_OVERCURRENT;
        end else if (tmr_count >= hold_r && idle_cnt_r >= hold_r) begin
          state_nxt = ors_pkg::S_AWAIT;
        end
      end
      ors_pkg::S_POWER_DOWN: begin
        if (!supply_session_valid) begin
          state_nxt = ors_pkg::S_REST;
        end
      end
      ors_pkg::S_OVERCURRENT: begin
        if (plug_sense || clr_err) begin
          state_nxt = ors_pkg::S_POWER_DOWN;
        end
      end
    endcase
    // Permit lives until the swap attempt is over
    permit_nxt = permit_r;
    if (state_r == ors_pkg::S_HOSTING && state_nxt == ors_pkg::S_SUSPENDED) begin
      permit_nxt = permit_ok;
    end else if (state_nxt != ors_pkg::S_SUSPENDED && state_nxt != ors_pkg::S_PERIPHERAL) begin
      permit_nxt = 1'b0;
    end
    armed_nxt = (state_nxt == ors_pkg::S_SUSPENDED) & permit_nxt;
    pullup_nxt = state_nxt == ors_pkg::S_PERIPHERAL;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ors_pkg::S_REST;
      permit_r <= 1'b0;
      armed_r <= 1'b0;
      pullup_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      permit_r <= permit_nxt;
      armed_r <= armed_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and status
  // ----------------------------------------------------------------
  assign drive_supply = (state_r != ors_pkg::S_REST) & (state_r != ors_pkg::S_POWER_DOWN) &
                        (state_r != ors_pkg::S_OVERCURRENT);
  assign pullup_en = pullup_r;
  assign bus_reset_drive = (state_r == ors_pkg::S_HOSTING) & ~reset_done;
  assign sof_enable = (state_r == ors_pkg::S_HOSTING) & reset_done;
  assign link_suspend = state_r == ors_pkg::S_SUSPENDED;
  assign role_b_start = (state_r == ors_pkg::S_REST) & plug_sense;

  always_comb begin
    status = 32'h0;
    status[`ORS_S_STATE_HI:`ORS_S_STATE_LO] = state_r;
    status[`ORS_S_DRIVE] = drive_supply;
    status[`ORS_S_PULLUP] = pullup_r;
    status[`ORS_S_LINK_SUSP] = link_suspend;
    status[`ORS_S_ATTACHED] = attached_r;
    status[`ORS_S_UNSUPPORTED] = unsup_r;
    status[`ORS_S_INCAPABLE] = incap_r;
    status[`ORS_S_PERMIT] = permit_r;
    status[`ORS_S_ARMED] = armed_r;
    // Suspended without permit to a swap-capable peer: software owes a return
    status[`ORS_S_RETURN_DUE] = link_suspend & ~permit_r & ctrl_r[`ORS_C_SWAP_CAPABLE] & ~incap_r;
    status[`ORS_S_B_START] = role_b_start;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_enter_hosting;
    state_r == ors_pkg::S_HOSTING && $past(state_r) != ors_pkg::S_HOSTING;
  endsequence
  sequence s_reset_driven;
    bus_reset_drive && !sof_enable;
  endsequence

  property p_rest_ramp;
    state_r == ors_pkg::S_REST && !plug_sense && !drop && (ctrl_r[`ORS_C_BUS_USE] || session_request_seen)
      |=> state_r == ors_pkg::S_RAMP;
  endproperty
  a_rest_ramp: assert property (p_rest_ramp) else $error("rest did not ramp");
  property p_ramp_await;
    state_r == ors_pkg::S_RAMP && !plug_sense && !drop && supply_valid |=> state_r == ors_pkg::S_AWAIT;
  endproperty
  a_ramp_await: assert property (p_ramp_await) else $error("ramp did not advance");
  property p_await_oc;
    state_r == ors_pkg::S_AWAIT && !plug_sense && !drop && !tmr_expired && !supply_valid
      |=> state_r == ors_pkg::S_OVERCURRENT;
  endproperty
  a_await_oc: assert property (p_await_oc) else $error("supply loss missed");
  property p_host_oc;
    state_r == ors_pkg::S_HOSTING && !plug_sense && !drop && attached_r && !supply_valid
      |=> state_r == ors_pkg::S_OVERCURRENT;
  endproperty
  a_host_oc: assert property (p_host_oc) else $error("hosting ignored supply loss");
  property p_host_reset;
    s_enter_hosting |-> s_reset_driven;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("no bus reset on hosting entry");
  property p_detach_pullup;
    state_r == ors_pkg::S_SUSPENDED && permit_r && line_se0 && !local_tx_active && !plug_sense && !drop
      && !tmr_expired && supply_valid |=> pullup_en ##1 pullup_en;
  endproperty
  a_detach_pullup: assert property (p_detach_pullup) else $error("pullup late after detach");
  property p_pullup_after_se0;
    $rose(pullup_en) |-> $past(line_se0) && $past(state_r) == ors_pkg::S_SUSPENDED;
  endproperty
  a_pullup_after_se0: assert property (p_pullup_after_se0) else $error("attach before detach");
  property p_hold_attach;
    $fell(pullup_en) && state_r == ors_pkg::S_AWAIT |-> $past(tmr_count) >= hold_r;
  endproperty
  a_hold_attach: assert property (p_hold_attach) else $error("attach dropped too soon");
  property p_await_host;
    state_r == ors_pkg::S_AWAIT && attached_r && supply_valid && !plug_sense && !drop && !tmr_expired
      |=> state_r == ors_pkg::S_HOSTING;
  endproperty
  a_await_host: assert property (p_await_host) else $error("attach not hosted");
  property p_plug_down;
    plug_sense && (state_r == ors_pkg::S_AWAIT || state_r == ors_pkg::S_PERIPHERAL)
      |=> state_r == ors_pkg::S_POWER_DOWN;
  endproperty
  a_plug_down: assert property (p_plug_down) else $error("plug removal missed");

endmodule

//--- ors_peer.sv
/*
  Model of the peer dual-role controller on the shared cable.
  Assumes the bench changes attach and want_swap just after ref_clk edges.
*/
`timescale 1ns/1ps

module ors_peer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic attach,
  input wire logic want_swap,
  input wire logic link_suspend,
  input wire logic pullup_en,
  output logic line_dp,
  output logic line_dm
);
  logic gone_r;
  logic gone_nxt;
  logic [2:0] brst_r;
  logic [2:0] brst_nxt;
  logic brst_on;

  // Detach only once the link is suspended, then wait for the other end
  always_comb begin
    gone_nxt = gone_r & want_swap;
    if (want_swap && link_suspend) begin
      gone_nxt = 1'b1;
    end
    // Host left suspend without attaching: it resumed or reset, so it keeps the bus
    if (!link_suspend && !pullup_en) begin
      gone_nxt = 1'b0;
    end
    brst_nxt = 3'h0;
    if (gone_r && pullup_en) begin
      brst_nxt = (brst_r == 3'h4) ? brst_r : brst_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gone_r <= 1'b0;
      brst_r <= 3'h0;
    end else begin
      gone_r <= gone_nxt;
      brst_r <= brst_nxt;
    end
  end

  // New host drives a short bus reset right after the other end attaches
  assign brst_on = (brst_r != 3'h0) & (brst_r != 3'h4);

  // Host pull-downs give SE0 when nobody pulls D+; J after detach means accepted
  assign line_dp = ((attach & ~gone_r) | pullup_en) & ~brst_on;
  assign line_dm = 1'b0;
endmodule

//--- testbench.sv
/*
  Self-checking bench for the session controller.
  Assumes the shortened timer counts set at the instance below and by t_reset.
*/
`timescale 1ns/1ps

module testbench;
  logic ref_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic plug_sense = 1'b0, supply_valid = 1'b0, supply_session_valid = 1'b0, session_request_seen = 1'b0;
  logic local_tx_active = 1'b0, att = 1'b0, swp = 1'b0;
  logic wb_ack_o, line_dp, line_dm, drive_supply, pullup_en, bus_reset_drive, sof_enable, link_suspend;
  logic role_b_start;
  int n_fail = 0, n_checks = 0, tick = 0, k;

  ors_fsm #(.RAMP_CYC(20), .AWAIT_CYC(200), .SUSP_CYC(300), .DEB_CYC(4), .RST_CYC(8))
    i_dut (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .plug_sense, .supply_valid, .supply_session_valid,
    .session_request_seen, .line_dp, .line_dm, .local_tx_active, .drive_supply, .pullup_en,
    .bus_reset_drive, .sof_enable, .link_suspend, .role_b_start);
  ors_peer i_peer (.ref_clk, .nrst, .attach(att), .want_swap(swp), .link_suspend, .pullup_en,
    .line_dp, .line_dm);

  always #12.5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic st(input logic [2:0] e);
    wb(1'b0, 8'h04, 32'h0);
    chk(q & 32'h7, {29'h0, e});
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'd20);
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h18, 32'ha);
    wb(1'b0, 8'h18, 32'h0);
    chk(q, 32'ha);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0001d4c0);
    st(3'd0);
  endtask

  task automatic t_fault;
    session_request_seen <= 1'b1;
    st(3'd1);
    hold(25);
    session_request_seen <= 1'b0;
    st(3'd7);
    wb(1'b1, 8'h00, 32'h80);
    st(3'd0);
  endtask

  task automatic t_timeout;
    wb(1'b1, 8'h00, 32'h3);
    st(3'd0);
    {supply_valid, supply_session_valid} <= 2'b11;
    wb(1'b1, 8'h00, 32'h1);
    hold(2);
    st(3'd2);
    hold(210);
    st(3'd6);
    wb(1'b1, 8'h00, 32'h0);
    supply_session_valid <= 1'b0;
    st(3'd0);
  endtask

  task automatic t_swap;
    supply_session_valid <= 1'b1;
    att <= 1'b1;
    wb(1'b1, 8'h00, 32'h1);
    for (k = 0; k < 20 && bus_reset_drive !== 1'b1; k++) @(posedge ref_clk);
    chk(bus_reset_drive, 1'b1);
    hold(10);
    chk(sof_enable, 1'b1);
    chk(drive_supply, 1'b1);
    wb(1'b1, 8'h00, 32'h10d);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h108);
    wb(1'b1, 8'h00, 32'h140);
    st(3'd4);
    chk(q & 32'h800, 32'h800);
    wb(1'b1, 8'h00, 32'h101);
    hold(10);
    wb(1'b1, 8'h00, 32'h120);
    st(3'd3);
    chk(q & 32'h100, 32'h100);
    wb(1'b1, 8'h00, 32'h110);
    st(3'd4);
    chk(link_suspend, 1'b1);
    chk(pullup_en, 1'b0);
    swp <= 1'b1;
    for (k = 0; k < 10 && pullup_en !== 1'b1; k++) @(posedge ref_clk);
    chk(pullup_en, 1'b1);
    for (k = 0; k < 40 && pullup_en === 1'b1; k++) @(posedge ref_clk);
    chk({31'h0, k >= 10}, 32'h1);
    {plug_sense, supply_session_valid, att, swp} <= 4'b1000;
    hold(8);
    chk(role_b_start, 1'b1);
    st(3'd0);
    chk(drive_supply, 1'b0);
  endtask

  task results;
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    tick <= tick + 1;
    if (tick == 5000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    hold(4);
    nrst <= 1'b1;
    t_reset();
    t_fault();
    t_timeout();
    t_swap();
    results();
  end
endmodule
